//--- verilog/dtc_timer.sv
// Dual timer/counter with four modes, APB register access
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_timer
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic unit0_gate_pin,
   input wire logic unit1_gate_pin,
   input wire logic unit0_count_pin,
   input wire logic unit1_count_pin,
   input wire logic unit0_vector_ack,
   input wire logic unit1_vector_ack,
   output logic unit0_clock_out_pin,
   output logic unit1_clock_out_pin,
   output logic unit0_overflow_flag,
   output logic unit1_overflow_flag
);
   // ======================================================================
   // Registers
   logic [7:0] timer_mode_register_ff;
   logic unit0_run_bit_ff;
   logic unit1_run_bit_ff;
   logic [3:0] wake_and_clock_out_register_ff;
   logic [7:0] unit0_low_byte_ff;
   logic [7:0] unit0_high_byte_ff;
   logic [7:0] unit1_low_byte_ff;
   logic [7:0] unit1_high_byte_ff;
   logic [31:0] prdata_ff;
   logic pready_ff;
   logic pslverr_ff;
   logic unit0_clock_out_pin_ff;
   logic unit1_clock_out_pin_ff;
   logic unit0_overflow_flag_ff;
   logic unit1_overflow_flag_ff;

   // ======================================================================
   // Pin synchronisers and prescaler
   logic g0_lvl;
   logic g1_lvl;
   logic c0_fall;
   logic c1_fall;
   logic slow_tick;

   dtc_edge_sync u_g0 (.pclk(pclk), .presetn(presetn), .pin(unit0_gate_pin),
      .level(g0_lvl), .fall());
   dtc_edge_sync u_g1 (.pclk(pclk), .presetn(presetn), .pin(unit1_gate_pin),
      .level(g1_lvl), .fall());
   dtc_edge_sync u_c0 (.pclk(pclk), .presetn(presetn), .pin(unit0_count_pin),
      .level(), .fall(c0_fall));
   dtc_edge_sync u_c1 (.pclk(pclk), .presetn(presetn), .pin(unit1_count_pin),
      .level(), .fall(c1_fall));
   dtc_prescale #(.DIV(`DTC_SLOW_DIV)) u_pre (.pclk(pclk), .presetn(presetn),
      .tick(slow_tick));

   // ======================================================================
   // Mode decode
   dtc_pkg::dtc_mode_t unit0_mode;
   dtc_pkg::dtc_mode_t unit1_mode;
   assign unit0_mode =
      dtc_pkg::dtc_mode_t'(timer_mode_register_ff[`DTC_MODE_U0_LSB +: 2]);
   assign unit1_mode =
      dtc_pkg::dtc_mode_t'(timer_mode_register_ff[`DTC_MODE_U1_LSB +: 2]);
   wire gate0 = timer_mode_register_ff[`DTC_MODE_U0_GATE];
   wire ct0 = timer_mode_register_ff[`DTC_MODE_U0_CT];
   wire gate1 = timer_mode_register_ff[`DTC_MODE_U1_GATE];
   wire ct1 = timer_mode_register_ff[`DTC_MODE_U1_CT];
   wire fast0 = wake_and_clock_out_register_ff[`DTC_CLKO_U0_FAST];
   wire fast1 = wake_and_clock_out_register_ff[`DTC_CLKO_U1_FAST];

   // Tick source for a unit
   function automatic logic src_tick(input logic ct, input logic fall, input logic fast,
      input logic slow);
      src_tick = ct ? fall : (fast | slow);
   endfunction : src_tick

   wire tick0 = src_tick(ct0, c0_fall, fast0, slow_tick);
   wire tick1 = src_tick(ct1, c1_fall, fast1, slow_tick);
   wire en0 = unit0_run_bit_ff & (~gate0 | g0_lvl);
   wire en1 = unit1_run_bit_ff & (~gate1 | g1_lvl);
   wire split = (unit0_mode == dtc_pkg::DTC_MSPLIT);
   wire split_hi_tick = (fast0 | slow_tick) & unit1_run_bit_ff;
   wire inc0 = tick0 & en0;
   wire inc1 = tick1 & en1 & (unit1_mode != dtc_pkg::DTC_MSPLIT);

   // ======================================================================
   // Unit next values
   logic [7:0] nxt_lo0;
   logic [7:0] nxt_hi0;
   logic [7:0] nxt_lo1;
   logic [7:0] nxt_hi1;
   logic ov0;
   logic ov1;
   logic ov_hi0;

   function automatic void step(input dtc_pkg::dtc_mode_t m, input logic [7:0] lo,
      input logic [7:0] hi, output logic [7:0] nlo, output logic [7:0] nhi, output logic ov);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0] c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      c16 = {1'b0, hi, lo} + 17'h00001;
      c8 = {1'b0, lo} + 9'h001;
      nlo = lo;
      nhi = hi;
      ov = 1'b0;
      case (m)
         dtc_pkg::DTC_M13:
         begin
            nlo = {lo[7:5], c13[4:0]};
            nhi = c13[12:5];
            ov = c13[13];
         end
         dtc_pkg::DTC_M16:
         begin
            nlo = c16[7:0];
            nhi = c16[15:8];
            ov = c16[16];
         end
         dtc_pkg::DTC_M8R, dtc_pkg::DTC_MSPLIT:
         begin
            nlo = c8[8] && m == dtc_pkg::DTC_M8R ? hi : c8[7:0];
            ov = c8[8];
         end
         default:
         begin
            ov = 1'b0;
         end
      endcase
   endfunction : step

   always_comb
   begin
      step(unit0_mode, unit0_low_byte_ff, unit0_high_byte_ff, nxt_lo0, nxt_hi0, ov0);
      step(unit1_mode, unit1_low_byte_ff, unit1_high_byte_ff, nxt_lo1, nxt_hi1, ov1);
      ov_hi0 = (unit0_high_byte_ff == 8'hff);
   end

   wire pulse0 = inc0 & ov0;
   wire pulse1 = inc1 & ov1;
   wire pulse_hi0 = split & split_hi_tick & ov_hi0;
   wire set_f0 = pulse0;
   wire set_f1 = split ? pulse_hi0 : pulse1;

   // ======================================================================
   // APB decode
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire hit_mode = (paddr == `DTC_ADDR_MODE);
   wire hit_ctrl = (paddr == `DTC_ADDR_CTRL);
   wire hit_l0 = (paddr == `DTC_ADDR_U0_LOW);
   wire hit_h0 = (paddr == `DTC_ADDR_U0_HIGH);
   wire hit_l1 = (paddr == `DTC_ADDR_U1_LOW);
   wire hit_h1 = (paddr == `DTC_ADDR_U1_HIGH);
   wire hit_clko = (paddr == `DTC_ADDR_CLKO);
   wire mapped = hit_mode | hit_ctrl | hit_l0 | hit_h0 | hit_l1 | hit_h1 | hit_clko;
   wire [7:0] ctrl_rd = {unit1_overflow_flag_ff, unit1_run_bit_ff, unit0_overflow_flag_ff,
      unit0_run_bit_ff, 4'h0};
   wire [7:0] rd_byte = hit_mode ? timer_mode_register_ff :
      hit_ctrl ? ctrl_rd :
      hit_l0 ? unit0_low_byte_ff :
      hit_h0 ? unit0_high_byte_ff :
      hit_l1 ? unit1_low_byte_ff :
      hit_h1 ? unit1_high_byte_ff :
      hit_clko ? {4'h0, wake_and_clock_out_register_ff} : 8'h00;
   wire wc = wr & hit_ctrl;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h00000000;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end
      else
      begin
         pready_ff <= psel & ~penable;
         pslverr_ff <= psel & ~penable & ~mapped;
         prdata_ff <= (psel & ~penable & ~pwrite) ? {24'h000000, rd_byte} : prdata_ff;
      end
   end

   // ======================================================================
   // Configuration registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_mode_register_ff <= `DTC_RST_BYTE;
         wake_and_clock_out_register_ff <= 4'h0;
         unit0_run_bit_ff <= 1'b0;
         unit1_run_bit_ff <= 1'b0;
      end
      else
      begin
         if (wr & hit_mode)
            timer_mode_register_ff <= pwdata[7:0];
         if (wr & hit_clko)
            wake_and_clock_out_register_ff <= pwdata[3:0];
         if (wc)
         begin
            unit0_run_bit_ff <= pwdata[`DTC_CTRL_U0_RUN];
            unit1_run_bit_ff <= pwdata[`DTC_CTRL_U1_RUN];
         end
      end
   end

   // ======================================================================
   // Flags: hardware set wins over clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit0_overflow_flag_ff <= 1'b0;
         unit1_overflow_flag_ff <= 1'b0;
      end
      else
      begin
         if (set_f0)
            unit0_overflow_flag_ff <= 1'b1;
         else if (unit0_vector_ack | (wc & ~pwdata[`DTC_CTRL_U0_FLAG]))
            unit0_overflow_flag_ff <= 1'b0;
         if (set_f1)
            unit1_overflow_flag_ff <= 1'b1;
         else if (unit1_vector_ack | (wc & ~pwdata[`DTC_CTRL_U1_FLAG]))
            unit1_overflow_flag_ff <= 1'b0;
      end
   end

   // ======================================================================
   // Count registers; software write has priority, run bit never clears
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit0_low_byte_ff <= `DTC_RST_BYTE;
         unit0_high_byte_ff <= `DTC_RST_BYTE;
         unit1_low_byte_ff <= `DTC_RST_BYTE;
         unit1_high_byte_ff <= `DTC_RST_BYTE;
      end
      else
      begin
         if (wr & hit_l0)
            unit0_low_byte_ff <= pwdata[7:0];
         else if (inc0)
            unit0_low_byte_ff <= nxt_lo0;
         if (wr & hit_h0)
            unit0_high_byte_ff <= pwdata[7:0];
         else if (split)
            unit0_high_byte_ff <= split_hi_tick ? unit0_high_byte_ff + 8'h01 : unit0_high_byte_ff;
         else if (inc0)
            unit0_high_byte_ff <= nxt_hi0;
         if (wr & hit_l1)
            unit1_low_byte_ff <= pwdata[7:0];
         else if (inc1)
            unit1_low_byte_ff <= nxt_lo1;
         if (wr & hit_h1)
            unit1_high_byte_ff <= pwdata[7:0];
         else if (inc1)
            unit1_high_byte_ff <= nxt_hi1;
      end
   end

   // ======================================================================
   // Clock-out latches
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         unit0_clock_out_pin_ff <= 1'b0;
         unit1_clock_out_pin_ff <= 1'b0;
      end
      else
      begin
         if (pulse0 & wake_and_clock_out_register_ff[`DTC_CLKO_U0_EN])
            unit0_clock_out_pin_ff <= ~unit0_clock_out_pin_ff;
         if (pulse1 & wake_and_clock_out_register_ff[`DTC_CLKO_U1_EN])
            unit1_clock_out_pin_ff <= ~unit1_clock_out_pin_ff;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign unit0_clock_out_pin = unit0_clock_out_pin_ff;
   assign unit1_clock_out_pin = unit1_clock_out_pin_ff;
   assign unit0_overflow_flag = unit0_overflow_flag_ff;
   assign unit1_overflow_flag = unit1_overflow_flag_ff;

   // ======================================================================
   // Assertions
   run_keeps_a: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(unit0_run_bit_ff) && $past(!(wr & (hit_l0 | hit_h0)))
      |-> unit0_low_byte_ff == $past(unit0_low_byte_ff))
      else $error("Run bit changed count");
   flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      set_f0 |=> unit0_overflow_flag_ff)
      else $error("Overflow flag not set");
   stop_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit1_mode == dtc_pkg::DTC_MSPLIT && !(wr & hit_l1) |=> $stable(unit1_low_byte_ff))
      else $error("Unit 1 counted in mode 3");
   gate_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      !unit0_run_bit_ff && !(wr & hit_l0) |=> $stable(unit0_low_byte_ff))
      else $error("Counted while stopped");
   reload_val_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit0_mode == dtc_pkg::DTC_M8R && pulse0 && !(wr & (hit_l0 | hit_h0))
      |=> unit0_low_byte_ff == unit0_high_byte_ff)
      else $error("Reload value wrong");
   clko_tog_a: assert property (@(posedge pclk) disable iff (!presetn)
      pulse0 && wake_and_clock_out_register_ff[`DTC_CLKO_U0_EN]
      |=> unit0_clock_out_pin_ff != $past(unit0_clock_out_pin_ff))
      else $error("Clock out did not toggle");
   hi_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
      split && pulse_hi0 |=> unit1_overflow_flag_ff)
      else $error("Split high byte flag missing");
   ack_clr_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit0_vector_ack && !set_f0 |=> !unit0_overflow_flag_ff)
      else $error("Vector did not clear flag");
   short_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit0_mode == dtc_pkg::DTC_M13 && inc0 && !(wr & (hit_l0 | hit_h0))
      && {unit0_high_byte_ff, unit0_low_byte_ff[4:0]} == 13'h1fff
      |=> {unit0_high_byte_ff, unit0_low_byte_ff[4:0]} == 13'h0000 && unit0_overflow_flag_ff)
      else $error("Mode 0 did not wrap");
   full_wrap_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit0_mode == dtc_pkg::DTC_M16 && inc0 && !(wr & (hit_l0 | hit_h0))
      && {unit0_high_byte_ff, unit0_low_byte_ff} == 16'hffff
      |=> {unit0_high_byte_ff, unit0_low_byte_ff} == 16'h0000 && unit0_overflow_flag_ff)
      else $error("Mode 1 did not wrap");
   reload_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
      unit0_mode == dtc_pkg::DTC_M8R && pulse0 && !(wr & hit_h0)
      |=> $stable(unit0_high_byte_ff))
      else $error("Reload changed high byte");
   split_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
      split && !unit1_run_bit_ff && !(wr & hit_h0) |=> $stable(unit0_high_byte_ff))
      else $error("Split high byte ran without run bit");
   gate_low_a: assert property (@(posedge pclk) disable iff (!presetn)
      gate0 && !g0_lvl && !(wr & hit_l0) |=> $stable(unit0_low_byte_ff))
      else $error("Counted with gate pin low");
   fast_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
      !ct0 && fast0 && en0 && unit0_mode == dtc_pkg::DTC_M8R && !ov0 && !(wr & hit_l0)
      |=> unit0_low_byte_ff == $past(unit0_low_byte_ff) + 8'h01)
      else $error("Fast tick missed");
endmodule : dtc_timer

//--- verilog/dtc_defines.svh
// Register offsets, field positions, reset values and timing counts for the dual timer
// What this block does
// - Mode 0 is a wrapping 13-bit counter
// - Mode 0 count: high byte, five low bits
// - Wrap to zero sets the unit overflow flag
// - Count needs run bit and gate or pin
// - Setting run bit keeps the count registers
// - Gate select bits at mode bits 7, 3
// - Mode 1 counts all sixteen bits
// - Mode 2 reloads low byte from high byte
// - Unit 0 clock out toggles on overflow
// - Unit 0 clock out rate from reload byte
// - Unit 1 clock out toggles likewise
// - Unit 1 in mode 3 holds its count
// - Split low byte uses unit 0 controls
// - Split high byte uses unit 1 run
// - Unit 1 runs without flag while unit 0 split
// - Two-bit mode field selects the four modes
// - Counter select picks clock or count pin
// - Flags clear on interrupt vector or software
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define DTC_ADDR_MODE 12'h000
`define DTC_ADDR_CTRL 12'h004
`define DTC_ADDR_U0_LOW 12'h008
`define DTC_ADDR_U0_HIGH 12'h00c
`define DTC_ADDR_U1_LOW 12'h010
`define DTC_ADDR_U1_HIGH 12'h014
`define DTC_ADDR_CLKO 12'h018

// ==========================================================================
// Field positions
`define DTC_MODE_U1_LSB 4
`define DTC_MODE_U0_LSB 0
`define DTC_MODE_U1_GATE 7
`define DTC_MODE_U1_CT 6
`define DTC_MODE_U0_GATE 3
`define DTC_MODE_U0_CT 2
`define DTC_CTRL_U1_FLAG 7
`define DTC_CTRL_U1_RUN 6
`define DTC_CTRL_U0_FLAG 5
`define DTC_CTRL_U0_RUN 4
`define DTC_CLKO_U0_EN 0
`define DTC_CLKO_U1_EN 1
`define DTC_CLKO_U0_FAST 2
`define DTC_CLKO_U1_FAST 3

// ==========================================================================
// Reset values and timing
`define DTC_RST_BYTE 8'h00
`define DTC_SLOW_DIV 12

`endif

//--- verilog/dtc_pkg.sv
// Types shared by the dual timer files
package dtc_pkg;
   typedef enum logic [1:0] {DTC_M13, DTC_M16, DTC_M8R, DTC_MSPLIT} dtc_mode_t;
endpackage : dtc_pkg

//--- verilog/dtc_edge_sync.sv
// Two-stage synchroniser with falling edge detect for one pin
`timescale 1ns/1ps
module dtc_edge_sync
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pin,
   output logic level,
   output logic fall
);
   logic meta_ff;
   logic sync_ff;
   logic last_ff;

   // ======================================================================
   // Synchroniser
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= 1'b1;
         sync_ff <= 1'b1;
         last_ff <= 1'b1;
      end
      else
      begin
         meta_ff <= pin;
         sync_ff <= meta_ff;
         last_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign fall = last_ff & ~sync_ff;
endmodule : dtc_edge_sync

//--- verilog/dtc_prescale.sv
// Divide-by-twelve tick generator for the slow timer rate
`timescale 1ns/1ps
`include "dtc_defines.svh"
module dtc_prescale
#(
   parameter int DIV = `DTC_SLOW_DIV
)
(
   input wire logic pclk,
   input wire logic presetn,
   output logic tick
);
   logic [7:0] cnt_ff;
   wire last = (cnt_ff == 8'(DIV - 1));

   if (DIV < 2 || DIV > 256)
   begin : g_div_check
      $error("DIV out of range");
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cnt_ff <= 8'h00;
      else
         cnt_ff <= last ? 8'h00 : cnt_ff + 8'h01;
   end

   assign tick = last;
endmodule : dtc_prescale

//--- verif/dtc_pin_model.sv
// Far-side model of the gate and count pins of both units
`timescale 1ns/1ps
module dtc_pin_model
(
   input wire logic pclk,
   output logic unit0_gate_pin,
   output logic unit1_gate_pin,
   output logic unit0_count_pin,
   output logic unit1_count_pin
);
   // =======================================================
   // Idle levels: gates open, count pins resting high
   initial
   begin
      unit0_gate_pin = 1'b1;
      unit1_gate_pin = 1'b1;
      unit0_count_pin = 1'b1;
      unit1_count_pin = 1'b1;
   end

   // =======================================================
   // Gate level held while count pin pulses are counted
   task set_gate(input int u, input logic v);
      @(posedge pclk);
      if (u == 0)
         unit0_gate_pin <= v;
      else
         unit1_gate_pin <= v;
   endtask : set_gate

   // Falling edges, low held gap cycles and high gap plus one between pulses, so prompt or slow
   task pulses(input int u, input int n, input int gap);
      repeat (n)
      begin
         @(posedge pclk);
         if (u == 0)
            unit0_count_pin <= 1'b0;
         else
            unit1_count_pin <= 1'b0;
         repeat (gap) @(posedge pclk);
         if (u == 0)
            unit0_count_pin <= 1'b1;
         else
            unit1_count_pin <= 1'b1;
         repeat (gap) @(posedge pclk);
      end
   endtask : pulses
endmodule : dtc_pin_model

//--- verif/tb.sv
// Self-checking bench for the dual timer
`timescale 1ns/1ps
`include "dtc_defines.svh"
`define CHK(a, b) \
   begin \
      total_checks++; \
      if ((a) !== (b)) \
      begin \
         miscompares++; \
         $display("[ERR] %0t got %h want %h", $time, (a), (b)); \
      end \
   end
module tb;
   typedef struct packed {
      logic [7:0] mode, run, gate, lo, hi, n, elo, ehi, ef, mask;
   } dtc_row_t;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, err;
   logic ack0 = 1'b0;
   logic ack1 = 1'b0;
   logic g0, g1, c0, c1, co0, co1, f0, f1;
   logic [7:0] q;
   int miscompares = 0;
   int total_checks = 0;
   int gap;
   dtc_row_t rows[8];

   always #12.5 pclk = ~pclk;

   dtc_timer u_dtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .unit0_gate_pin(g0), .unit1_gate_pin(g1), .unit0_count_pin(c0),
      .unit1_count_pin(c1), .unit0_vector_ack(ack0), .unit1_vector_ack(ack1),
      .unit0_clock_out_pin(co0), .unit1_clock_out_pin(co1), .unit0_overflow_flag(f0),
      .unit1_overflow_flag(f1));
   dtc_pin_model u_dtc_pin_model (.pclk(pclk), .unit0_gate_pin(g0), .unit1_gate_pin(g1),
      .unit0_count_pin(c0), .unit1_count_pin(c1));

   // =======================================================
   // Bus and measurement tasks
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      q = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task edge_gap(input int u);
      logic p;
      int k;
      k = 0;
      p = u ? co1 : co0;
      while ((u ? co1 : co0) === p && k < 300)
      begin
         @(posedge pclk);
         k++;
      end
      p = u ? co1 : co0;
      gap = 0;
      while ((u ? co1 : co0) === p && gap < 300)
      begin
         @(posedge pclk);
         gap++;
      end
   endtask : edge_gap

   task conclude;
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   initial
   begin
      repeat (20000) @(posedge pclk);
      miscompares++;
      conclude();
   end

   // =======================================================
   // Main sequence
   initial
   begin
      // mode run gate lo hi n elo ehi ef mask
      rows[0] = {8'h04, 8'h10, 8'h01, 8'h1f, 8'hff, 8'h01, 8'h00, 8'h00, 8'h01, 8'h1f};
      rows[1] = {8'h04, 8'h10, 8'h01, 8'h1e, 8'h12, 8'h03, 8'h01, 8'h13, 8'h00, 8'h1f};
      rows[2] = {8'h05, 8'h10, 8'h01, 8'hff, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'hff};
      rows[3] = {8'h05, 8'h10, 8'h01, 8'hff, 8'hff, 8'h02, 8'h01, 8'h00, 8'h01, 8'hff};
      rows[4] = {8'h06, 8'h10, 8'h01, 8'hfe, 8'hf0, 8'h03, 8'hf1, 8'hf0, 8'h01, 8'hff};
      rows[5] = {8'h0d, 8'h10, 8'h00, 8'h05, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'hff};
      rows[6] = {8'h0d, 8'h10, 8'h01, 8'h05, 8'h00, 8'h02, 8'h07, 8'h00, 8'h00, 8'hff};
      rows[7] = {8'h05, 8'h00, 8'h01, 8'h05, 8'h00, 8'h02, 8'h05, 8'h00, 8'h00, 8'hff};
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      `CHK({f0, f1, co0, co1}, 4'h0)
      apb(1'b0, `DTC_ADDR_MODE, 8'h00);
      `CHK(q, `DTC_RST_BYTE)
      apb(1'b0, 12'h01c, 8'h00);
      `CHK({err, q}, 9'h100)
      foreach (rows[i])
      begin
         apb(1'b1, `DTC_ADDR_CTRL, 8'h00);
         u_dtc_pin_model.set_gate(0, rows[i].gate[0]);
         apb(1'b1, `DTC_ADDR_MODE, rows[i].mode);
         apb(1'b1, `DTC_ADDR_U0_LOW, rows[i].lo);
         apb(1'b1, `DTC_ADDR_U0_HIGH, rows[i].hi);
         apb(1'b1, `DTC_ADDR_CTRL, rows[i].run);
         u_dtc_pin_model.pulses(0, int'(rows[i].n), 4);
         repeat (8) @(posedge pclk);
         apb(1'b1, `DTC_ADDR_CTRL, 8'h20);
         apb(1'b0, `DTC_ADDR_U0_LOW, 8'h00);
         `CHK(q & rows[i].mask, rows[i].elo)
         apb(1'b0, `DTC_ADDR_U0_HIGH, 8'h00);
         `CHK(q, rows[i].ehi)
         `CHK(f0, rows[i].ef[0])
         ack0 <= 1'b1;
         @(posedge pclk);
         ack0 <= 1'b0;
         @(posedge pclk);
         `CHK(f0, 1'b0)
      end
      for (int u = 0; u < 2; u++)
         for (int f = 0; f < 2; f++)
         begin
            apb(1'b1, `DTC_ADDR_CTRL, 8'h00);
            apb(1'b1, `DTC_ADDR_MODE, 8'h22);
            apb(1'b1, u ? `DTC_ADDR_U1_HIGH : `DTC_ADDR_U0_HIGH, 8'hfc);
            apb(1'b1, u ? `DTC_ADDR_U1_LOW : `DTC_ADDR_U0_LOW, 8'hfc);
            apb(1'b1, `DTC_ADDR_CLKO, (8'h01 << u) | (f ? (8'h04 << u) : 8'h00));
            apb(1'b1, `DTC_ADDR_CTRL, u ? 8'h40 : 8'h10);
            edge_gap(u);
            `CHK(gap, 4 * (f ? 1 : `DTC_SLOW_DIV))
         end
      apb(1'b1, `DTC_ADDR_CTRL, 8'h00);
      apb(1'b1, `DTC_ADDR_CLKO, 8'h04);
      apb(1'b1, `DTC_ADDR_MODE, 8'h73);
      apb(1'b1, `DTC_ADDR_U1_LOW, 8'h40);
      apb(1'b1, `DTC_ADDR_U0_HIGH, 8'hf0);
      apb(1'b1, `DTC_ADDR_CTRL, 8'h40);
      u_dtc_pin_model.pulses(1, 3, 2);
      repeat (4) @(posedge pclk);
      `CHK(f1, 1'b1)
      `CHK(f0, 1'b0)
      apb(1'b1, `DTC_ADDR_CTRL, 8'h80);
      apb(1'b0, `DTC_ADDR_U1_LOW, 8'h00);
      `CHK(q, 8'h40)
      `CHK(f1, 1'b1)
      ack1 <= 1'b1;
      @(posedge pclk);
      ack1 <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK(f1, 1'b0)
      // Mid-run reset returns outputs and registers to their reset state
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      `CHK({f0, f1, co0, co1}, 4'h0)
      presetn <= 1'b1;
      apb(1'b0, `DTC_ADDR_MODE, 8'h00);
      `CHK(q, `DTC_RST_BYTE)
      conclude();
   end
endmodule : tb
